// ==== verilog/eip_defines.vh ====
// Operation
// R01: Underflow flag sets below lower limit, clears once count falls below two thirds.
// R02: Overflow flag sets above upper limit, clears once count falls below one third.
// R03: Zero-pulse capture valid flag rises when track C captures the count.
// R04: External capture valid flag rises when the capture input captures the count.
// R05: Preset-done flag rises once a requested counter preset is carried out.
// R06: Fine count flagged invalid while speed is below the extrapolation minimum.
// R07: Levels of tracks A, B, C and gate reported as separate bits.
// R08: Capture input level reported in status word, and in main word in compatibility.
// R09: Compatibility with distributed clock: sync fault set when sync came without data.
// R10: Data validity bit reads 0 when input data valid, 1 when invalid.
// R11: Compatibility layout: toggle bit inverts at each input data update.
// R12: Two-bit wrapping cycle counter advances only when a new value exists.
// R13: 64-bit timestamp taken at every counter change, latest one presented.
// R14: Timestamp of latest rising edge on the zero-pulse input kept.
// R15: Timestamp of latest configured edge on the external capture input kept.
// R16: Gate used as second capture stores count and edge timestamp per edge enables.
// R17: Second-capture status 0 allows new capture, 1 blocks further captures.
// R18: Host software lock request echoed: 1 locked, 0 unlocked.
// R19: 16-bit duty-cycle value gives pulse duration over period.
// R20: Smallest duty cycle since last clear is tracked and reported.
// R21: Largest duty cycle since last clear is tracked and reported.
// R22: Flag raised when counting direction reverses.
// R23: A command clears the duty minimum or maximum of one channel to zero.
// R24: Two independent channels, each with its own complete input data set.
`ifndef EIP_DEFINES_VH
`define EIP_DEFINES_VH

`define EIP_NUM_CH            2
`define EIP_INPUT_ENTRIES     8'h25
`define EIP_STATUS_ENTRIES    8'h15
`define EIP_CLK_PERIOD_NS     10
`define EIP_STALL_TIME_US     10000
`define EIP_STALL_CYCLES      (`EIP_STALL_TIME_US * 1000 / `EIP_CLK_PERIOD_NS)
`define EIP_CMD_CLR_MIN       16'h9130
`define EIP_CMD_CLR_MAX       16'h9140
`define EIP_RATIO_FULL        16'hFFFF
`define EIP_RST_COUNT         32'h0000_0000
`define EIP_RST_TIME          64'h0000_0000_0000_0000
`define EIP_RST_RATIO         16'h0000
`define EIP_PIN_A             0
`define EIP_PIN_B             1
`define EIP_PIN_C             2
`define EIP_PIN_GATE          3
`define EIP_PIN_EXT           4
`define EIP_PIN_ALARM         5
`define EIP_PIN_BREAK         6
`define EIP_PIN_COUNT         7

`endif

// ==== verilog/eip_encoder_inputs.v ====
`timescale 1ns/10ps
`include "eip_defines.vh"

module eip_encoder_inputs #(
	parameter NUM_CH       = `EIP_NUM_CH,
	parameter STALL_CYCLES = `EIP_STALL_CYCLES
) (
	input  wire                       core_clk,
	input  wire                       sys_rst,
	input  wire [NUM_CH-1:0]          pin_track_a,
	input  wire [NUM_CH-1:0]          pin_track_b,
	input  wire [NUM_CH-1:0]          pin_track_c,
	input  wire [NUM_CH-1:0]          pin_gate,
	input  wire [NUM_CH-1:0]          pin_ext_capture,
	input  wire [NUM_CH-1:0]          pin_alarm,
	input  wire [NUM_CH-1:0]          pin_wire_break,
	input  wire                       compat_layout,
	input  wire                       distributed_clock_operation,
	input  wire                       sync_event,
	input  wire                       update_tick,
	input  wire [NUM_CH-1:0]          zero_capture_en,
	input  wire [NUM_CH-1:0]          ext_capture_pos_en,
	input  wire [NUM_CH-1:0]          ext_capture_neg_en,
	input  wire [NUM_CH-1:0]          gate_as_capture,
	input  wire [NUM_CH-1:0]          second_capture_pos_en,
	input  wire [NUM_CH-1:0]          second_capture_neg_en,
	input  wire [NUM_CH-1:0]          preset_req,
	input  wire [NUM_CH*32-1:0]       preset_value,
	input  wire [NUM_CH-1:0]          host_lock_req,
	input  wire [NUM_CH*32-1:0]       lower_limit,
	input  wire [NUM_CH*32-1:0]       upper_limit,
	input  wire                       cmd_strobe,
	input  wire [15:0]                cmd_code,
	output wire [7:0]                 input_entry_count,
	output wire [7:0]                 status_entry_count,
	output wire [NUM_CH-1:0]          zero_capture_valid,
	output wire [NUM_CH-1:0]          ext_capture_valid,
	output wire [NUM_CH-1:0]          preset_done,
	output wire [NUM_CH-1:0]          count_underflow,
	output wire [NUM_CH-1:0]          count_overflow,
	output wire [NUM_CH-1:0]          alarm_input_level,
	output wire [NUM_CH-1:0]          wire_break,
	output wire [NUM_CH-1:0]          interpolation_invalid,
	output wire [NUM_CH-1:0]          track_a_level,
	output wire [NUM_CH-1:0]          track_b_level,
	output wire [NUM_CH-1:0]          track_c_level,
	output wire [NUM_CH-1:0]          gate_level,
	output wire [NUM_CH-1:0]          ext_capture_level_compat,
	output wire [NUM_CH-1:0]          sync_fault_compat,
	output wire [NUM_CH-1:0]          data_invalid_compat,
	output wire [NUM_CH-1:0]          update_toggle_compat,
	output wire [NUM_CH*32-1:0]       count_value,
	output wire [NUM_CH*32-1:0]       captured_count,
	output wire [NUM_CH*64-1:0]       count_change_time,
	output wire [NUM_CH*64-1:0]       zero_edge_time,
	output wire [NUM_CH*64-1:0]       ext_capture_time,
	output wire [NUM_CH*64-1:0]       second_capture_time,
	output wire [NUM_CH*32-1:0]       second_captured_count,
	output wire [NUM_CH*16-1:0]       pulse_ratio,
	output wire [NUM_CH*16-1:0]       pulse_ratio_lowest,
	output wire [NUM_CH*16-1:0]       pulse_ratio_highest,
	output wire [NUM_CH-1:0]          data_invalid,
	output wire [NUM_CH*2-1:0]        update_cycle_count,
	output wire [NUM_CH-1:0]          host_lock_echo,
	output wire [NUM_CH-1:0]          second_capture_full,
	output wire [NUM_CH-1:0]          reversal_seen,
	output wire [NUM_CH-1:0]          ext_capture_level,
	output wire [NUM_CH-1:0]          count_outside_limits
);

	// Ratio of high time to period, full scale at 100 percent, saturating
	function [15:0] eip_ratio;
		input [15:0] high_cyc;
		input [15:0] period_cyc;
		reg   [31:0] quot;
		begin
			quot = 32'h0000_0000;
			if (period_cyc == 16'h0000) begin
				eip_ratio = `EIP_RATIO_FULL;
			end else begin
				quot = ({high_cyc, 16'h0000} - {16'h0000, high_cyc}) / {16'h0000, period_cyc};
				eip_ratio = (quot[31:16] != 16'h0000) ? `EIP_RATIO_FULL : quot[15:0];
			end
		end
	endfunction

	// Shared time base in nanoseconds, used by every timestamp
	reg [63:0] time_ns_ff;

	always @(posedge core_clk) begin
		if (sys_rst) begin
			time_ns_ff <= `EIP_RST_TIME;
		end else begin
			time_ns_ff <= time_ns_ff + `EIP_CLK_PERIOD_NS;
		end
	end

	assign input_entry_count  = `EIP_INPUT_ENTRIES;
	assign status_entry_count = `EIP_STATUS_ENTRIES;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g = g + 1) begin : ch // [R24]
			wire [`EIP_PIN_COUNT-1:0] pins_raw;
			reg  [`EIP_PIN_COUNT-1:0] sync1_ff;
			reg  [`EIP_PIN_COUNT-1:0] sync2_ff;
			reg  [`EIP_PIN_COUNT-1:0] prev_ff;
			wire [`EIP_PIN_COUNT-1:0] rise;
			wire [`EIP_PIN_COUNT-1:0] fall;
			wire [31:0] lo;
			wire [31:0] hi;
			wire [31:0] third;
			wire        step;
			wire        dir_up;
			wire        ext_hit;
			wire        sec_hit;
			wire        cmd_min;
			wire        cmd_max;
			reg  [31:0] count_ff;
			reg  [31:0] nxt_count;
			reg         nxt_ovf;
			reg         nxt_unf;
			reg         ovf_ff;
			reg         unf_ff;
			reg  [31:0] cap_ff;
			reg  [31:0] cap2_ff;
			reg         zvalid_ff;
			reg         evalid_ff;
			reg         full2_ff;
			reg         preset_prev_ff;
			reg         done_ff;
			reg         lock_ff;
			reg         dir_ff;
			reg         dir_known_ff;
			reg         rev_ff;
			reg  [63:0] t_cnt_ff;
			reg  [63:0] t_zero_ff;
			reg  [63:0] t_ext_ff;
			reg  [63:0] t_sec_ff;
			reg  [31:0] stall_ff;
			reg         stall_flag_ff;
			reg  [15:0] high_ff;
			reg  [15:0] period_ff;
			reg  [15:0] ratio_ff;
			reg  [15:0] rmin_ff;
			reg  [15:0] rmax_ff;
			reg         changed_ff;
			reg         nodata_ff;
			reg         sfault_ff;
			reg  [1:0]  cyc_ff;
			reg         tog_ff;

			assign pins_raw = {pin_wire_break[g], pin_alarm[g], pin_ext_capture[g],
				pin_gate[g], pin_track_c[g], pin_track_b[g], pin_track_a[g]};

			// Two-stage synchroniser; edges are taken only from the second stage
			always @(posedge core_clk) begin
				if (sys_rst) begin
					sync1_ff <= {`EIP_PIN_COUNT{1'b0}};
					sync2_ff <= {`EIP_PIN_COUNT{1'b0}};
					prev_ff  <= {`EIP_PIN_COUNT{1'b0}};
				end else begin
					sync1_ff <= pins_raw;
					sync2_ff <= sync1_ff;
					prev_ff  <= sync2_ff;
				end
			end

			assign rise    = sync2_ff & ~prev_ff;
			assign fall    = ~sync2_ff & prev_ff;
			assign lo      = lower_limit[g*32 +: 32];
			assign hi      = upper_limit[g*32 +: 32];
			assign third   = (hi - lo) / 32'h0000_0003;
			// Quadrature: exactly one track changed is a valid step
			assign step    = (rise[`EIP_PIN_A] | fall[`EIP_PIN_A]) ^
				(rise[`EIP_PIN_B] | fall[`EIP_PIN_B]);
			assign dir_up  = prev_ff[`EIP_PIN_A] ^ sync2_ff[`EIP_PIN_B];
			assign ext_hit = (rise[`EIP_PIN_EXT] & ext_capture_pos_en[g]) |
				(fall[`EIP_PIN_EXT] & ext_capture_neg_en[g]);
			assign sec_hit = gate_as_capture[g] &
				((rise[`EIP_PIN_GATE] & second_capture_pos_en[g]) |
				(fall[`EIP_PIN_GATE] & second_capture_neg_en[g]));
			assign cmd_min = cmd_strobe & (cmd_code == (`EIP_CMD_CLR_MIN + g)); // [R23]
			assign cmd_max = cmd_strobe & (cmd_code == (`EIP_CMD_CLR_MAX + g)); // [R23]

			// Counter with limit wrap; a preset overrides a step in the same cycle
			always @* begin
				nxt_count = count_ff;
				nxt_ovf   = ovf_ff;
				nxt_unf   = unf_ff;
				if (ovf_ff && (count_ff < lo + third)) begin
					nxt_ovf = 1'b0; // [R02]
				end
				if (unf_ff && (count_ff < lo + third + third)) begin
					nxt_unf = 1'b0; // [R01]
				end
				if (preset_req[g] && !preset_prev_ff) begin
					nxt_count = preset_value[g*32 +: 32]; // [R05]
				end else if (step && !lock_ff) begin
					if (dir_up) begin
						if (count_ff >= hi) begin
							nxt_count = lo;
							nxt_ovf   = 1'b1; // [R02]
						end else begin
							nxt_count = count_ff + 32'h0000_0001;
						end
					end else begin
						if (count_ff <= lo) begin
							nxt_count = hi;
							nxt_unf   = 1'b1; // [R01]
						end else begin
							nxt_count = count_ff - 32'h0000_0001;
						end
					end
				end
			end

			always @(posedge core_clk) begin
				if (sys_rst) begin
					count_ff       <= `EIP_RST_COUNT;
					ovf_ff         <= 1'b0;
					unf_ff         <= 1'b0;
					preset_prev_ff <= 1'b0;
					done_ff        <= 1'b0;
					lock_ff        <= 1'b0;
					t_cnt_ff       <= `EIP_RST_TIME;
				end else begin
					count_ff       <= nxt_count;
					ovf_ff         <= nxt_ovf;
					unf_ff         <= nxt_unf;
					preset_prev_ff <= preset_req[g];
					lock_ff        <= host_lock_req[g]; // [R18]
					// Done stays up while the request is held, drops with it
					if (preset_req[g] && !preset_prev_ff) begin
						done_ff <= 1'b1; // [R05]
					end else if (!preset_req[g]) begin
						done_ff <= 1'b0;
					end
					if (nxt_count != count_ff) begin
						t_cnt_ff <= time_ns_ff; // [R13]
					end
				end
			end

			// Captures: valid flags hold until the matching enable is withdrawn
			always @(posedge core_clk) begin
				if (sys_rst) begin
					cap_ff    <= `EIP_RST_COUNT;
					cap2_ff   <= `EIP_RST_COUNT;
					zvalid_ff <= 1'b0;
					evalid_ff <= 1'b0;
					full2_ff  <= 1'b0;
					t_zero_ff <= `EIP_RST_TIME;
					t_ext_ff  <= `EIP_RST_TIME;
					t_sec_ff  <= `EIP_RST_TIME;
				end else begin
					if (rise[`EIP_PIN_C]) begin
						t_zero_ff <= time_ns_ff; // [R14]
					end
					if (ext_hit) begin
						t_ext_ff <= time_ns_ff; // [R15]
					end
					if (rise[`EIP_PIN_C] && zero_capture_en[g] && !zvalid_ff) begin
						cap_ff    <= count_ff;
						zvalid_ff <= 1'b1; // [R03]
					end else if (!zero_capture_en[g]) begin
						zvalid_ff <= 1'b0;
					end
					if (ext_hit && !evalid_ff) begin
						cap_ff    <= count_ff;
						evalid_ff <= 1'b1; // [R04]
					end else if (!ext_capture_pos_en[g] && !ext_capture_neg_en[g]) begin
						evalid_ff <= 1'b0;
					end
					if (sec_hit && !full2_ff) begin
						cap2_ff  <= count_ff; // [R16]
						t_sec_ff <= time_ns_ff; // [R16]
						full2_ff <= 1'b1; // [R17]
					end else if (!second_capture_pos_en[g] && !second_capture_neg_en[g]) begin
						full2_ff <= 1'b0; // [R17]
					end
				end
			end

			// Direction reversal and low-speed detection
			always @(posedge core_clk) begin
				if (sys_rst) begin
					dir_ff        <= 1'b0;
					dir_known_ff  <= 1'b0;
					rev_ff        <= 1'b0;
					stall_ff      <= 32'h0000_0000;
					stall_flag_ff <= 1'b0;
				end else begin
					if (step && !lock_ff) begin
						dir_ff       <= dir_up;
						dir_known_ff <= 1'b1;
						stall_ff     <= 32'h0000_0000;
						stall_flag_ff <= 1'b0;
					end else if (stall_ff >= STALL_CYCLES - 1) begin
						stall_flag_ff <= 1'b1; // [R06]
					end else begin
						stall_ff <= stall_ff + 32'h0000_0001;
					end
					// Sticky until reported by an update; a new reversal wins over the clear
					if (step && !lock_ff && dir_known_ff && (dir_up != dir_ff)) begin
						rev_ff <= 1'b1; // [R22]
					end else if (update_tick) begin
						rev_ff <= 1'b0;
					end
				end
			end

			// Duty cycle from track A, evaluated at each rising edge
			always @(posedge core_clk) begin
				if (sys_rst) begin
					high_ff   <= 16'h0000;
					period_ff <= 16'h0000;
					ratio_ff  <= `EIP_RST_RATIO;
					rmin_ff   <= `EIP_RST_RATIO;
					rmax_ff   <= `EIP_RST_RATIO;
				end else begin
					if (rise[`EIP_PIN_A]) begin
						high_ff   <= 16'h0001;
						period_ff <= 16'h0001;
						ratio_ff  <= eip_ratio(high_ff, period_ff); // [R19]
					end else begin
						if (period_ff != 16'hFFFF) begin
							period_ff <= period_ff + 16'h0001;
						end
						if (sync2_ff[`EIP_PIN_A] && high_ff != 16'hFFFF) begin
							high_ff <= high_ff + 16'h0001;
						end
					end
					// Zero in the minimum means no sample since the last clear
					if (cmd_min) begin
						rmin_ff <= `EIP_RST_RATIO; // [R23]
					end else if (rmin_ff == `EIP_RST_RATIO || ratio_ff < rmin_ff) begin
						rmin_ff <= ratio_ff; // [R20]
					end
					if (cmd_max) begin
						rmax_ff <= `EIP_RST_RATIO; // [R23]
					end else if (ratio_ff > rmax_ff) begin
						rmax_ff <= ratio_ff; // [R21]
					end
				end
			end

			// Cyclic update bookkeeping seen by the reader
			always @(posedge core_clk) begin
				if (sys_rst) begin
					changed_ff <= 1'b0;
					nodata_ff  <= 1'b0;
					sfault_ff  <= 1'b0;
					cyc_ff     <= 2'h0;
					tog_ff     <= 1'b0;
				end else begin
					if (nxt_count != count_ff) begin
						changed_ff <= 1'b1;
					end else if (update_tick) begin
						changed_ff <= 1'b0;
					end
					if (update_tick && changed_ff) begin
						cyc_ff <= cyc_ff + 2'h1; // [R12]
						tog_ff <= compat_layout ? ~tog_ff : tog_ff; // [R11]
					end
					if (sync_event) begin
						nodata_ff <= 1'b1;
					end else if (update_tick) begin
						nodata_ff <= 1'b0;
					end
					// Fault reports the cycle that ended at this sync
					if (sync_event) begin
						sfault_ff <= compat_layout & distributed_clock_operation &
							nodata_ff; // [R09]
					end
				end
			end

			assign zero_capture_valid[g]       = zvalid_ff;
			assign ext_capture_valid[g]        = evalid_ff;
			assign preset_done[g]              = done_ff;
			assign count_underflow[g]          = unf_ff;
			assign count_overflow[g]           = ovf_ff;
			assign alarm_input_level[g]        = sync2_ff[`EIP_PIN_ALARM];
			assign wire_break[g]               = sync2_ff[`EIP_PIN_BREAK];
			assign interpolation_invalid[g]    = stall_flag_ff;
			assign track_a_level[g]            = sync2_ff[`EIP_PIN_A]; // [R07]
			assign track_b_level[g]            = sync2_ff[`EIP_PIN_B]; // [R07]
			assign track_c_level[g]            = sync2_ff[`EIP_PIN_C]; // [R07]
			assign gate_level[g]               = sync2_ff[`EIP_PIN_GATE]; // [R07]
			assign ext_capture_level[g]        = sync2_ff[`EIP_PIN_EXT]; // [R08]
			assign ext_capture_level_compat[g] = compat_layout & sync2_ff[`EIP_PIN_EXT]; // [R08]
			assign sync_fault_compat[g]        = sfault_ff;
			assign data_invalid[g]             = sync2_ff[`EIP_PIN_BREAK]; // [R10]
			assign data_invalid_compat[g]      = compat_layout & sync2_ff[`EIP_PIN_BREAK]; // [R10]
			assign update_toggle_compat[g]     = tog_ff;
			assign count_value[g*32 +: 32]           = count_ff;
			assign captured_count[g*32 +: 32]        = cap_ff;
			assign count_change_time[g*64 +: 64]     = t_cnt_ff;
			assign zero_edge_time[g*64 +: 64]        = t_zero_ff;
			assign ext_capture_time[g*64 +: 64]      = t_ext_ff;
			assign second_capture_time[g*64 +: 64]   = t_sec_ff;
			assign second_captured_count[g*32 +: 32] = cap2_ff;
			assign pulse_ratio[g*16 +: 16]           = ratio_ff;
			assign pulse_ratio_lowest[g*16 +: 16]    = rmin_ff;
			assign pulse_ratio_highest[g*16 +: 16]   = rmax_ff;
			assign update_cycle_count[g*2 +: 2]      = cyc_ff;
			assign host_lock_echo[g]                 = lock_ff;
			assign second_capture_full[g]            = full2_ff;
			assign reversal_seen[g]                  = rev_ff;
			assign count_outside_limits[g]           = (count_ff < lo) | (count_ff > hi);
		end
	endgenerate

endmodule // eip_encoder_inputs

// ==== bench/eip_encoder_inputs_checker.sv ====
`timescale 1ns/10ps
module eip_encoder_inputs_checker #(
	parameter NUM_CH = 2
) (
	input wire                 core_clk,
	input wire                 sys_rst,
	input wire [NUM_CH*32-1:0] preset_value,
	input wire [NUM_CH*32-1:0] lower_limit,
	input wire [NUM_CH*32-1:0] upper_limit,
	input wire                 compat_layout,
	input wire                 update_tick,
	input wire [NUM_CH-1:0]    zero_capture_en,
	input wire [NUM_CH-1:0]    zero_capture_valid,
	input wire [NUM_CH-1:0]    preset_done,
	input wire [NUM_CH-1:0]    count_underflow,
	input wire [NUM_CH-1:0]    count_overflow,
	input wire [NUM_CH-1:0]    ext_capture_level,
	input wire [NUM_CH-1:0]    ext_capture_level_compat,
	input wire [NUM_CH-1:0]    data_invalid,
	input wire [NUM_CH-1:0]    data_invalid_compat,
	input wire [NUM_CH-1:0]    update_toggle_compat,
	input wire [NUM_CH*32-1:0] count_value,
	input wire [NUM_CH*2-1:0]  update_cycle_count
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	property p_udf;
		$rose(count_underflow[0]) |-> count_value[31:0] == upper_limit[31:0];
	endproperty
	a_udf: assert property (p_udf) else $error("underflow without wrap to upper");
	property p_ovf;
		$rose(count_overflow[0]) |-> count_value[31:0] == lower_limit[31:0];
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow without wrap to lower");
	property p_zcap;
		$rose(zero_capture_valid[0]) |-> $past(zero_capture_en[0]);
	endproperty
	a_zcap: assert property (p_zcap) else $error("zero capture while disabled");
	property p_pre;
		$rose(preset_done[0]) |-> count_value[31:0] == $past(preset_value[31:0]);
	endproperty
	a_pre: assert property (p_pre) else $error("preset done with wrong count");
	property p_extc;
		ext_capture_level_compat[0] |-> ext_capture_level[0] && compat_layout;
	endproperty
	a_extc: assert property (p_extc) else $error("compat capture level wrong");
	property p_inv;
		data_invalid_compat[0] |-> data_invalid[0] && compat_layout;
	endproperty
	a_inv: assert property (p_inv) else $error("compat invalid bit wrong");
	property p_tog;
		$changed(update_toggle_compat[0]) |-> $past(update_tick && compat_layout);
	endproperty
	a_tog: assert property (p_tog) else $error("toggle moved without update");
	property p_ucc;
		$changed(update_cycle_count[1:0]) |-> $past(update_tick)
			&& update_cycle_count[1:0] == $past(update_cycle_count[1:0]) + 2'h1;
	endproperty
	a_ucc: assert property (p_ucc) else $error("cycle counter step wrong");
endmodule // eip_encoder_inputs_checker

bind eip_encoder_inputs eip_encoder_inputs_checker #(
	.NUM_CH(NUM_CH)
) i_eip_encoder_inputs_checker (
	.core_clk, .sys_rst, .preset_value, .lower_limit, .upper_limit, .compat_layout,
	.update_tick, .zero_capture_en, .zero_capture_valid, .preset_done, .count_underflow,
	.count_overflow, .ext_capture_level, .ext_capture_level_compat, .data_invalid,
	.data_invalid_compat, .update_toggle_compat, .count_value, .update_cycle_count
);

// ==== bench/eip_bus_master_model.sv ====
`timescale 1ns/10ps
module eip_bus_master_model #(
	parameter PERIOD = 30
) (
	input  wire core_clk,
	input  wire sys_rst,
	input  wire run,
	input  wire skip,
	output reg  update_tick,
	output reg  sync_event
);
	reg [7:0] cyc_ff;
	// Tick comes before each sync, so only skip makes a fault
	always @(negedge core_clk) begin
		if (sys_rst || !run) begin
			cyc_ff <= 8'h00;
			update_tick <= 1'b0;
			sync_event <= 1'b0;
		end else begin
			cyc_ff <= (cyc_ff == PERIOD - 1) ? 8'h00 : cyc_ff + 8'h01;
			update_tick <= !skip && cyc_ff == PERIOD - 3;
			sync_event <= cyc_ff == PERIOD - 1;
		end
	end
endmodule // eip_bus_master_model

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	reg         core_clk, sys_rst, compat_layout, distributed_clock_operation;
	reg         cmd_strobe, run, skip, t, ovf_seen, udf_seen;
	reg  [1:0]  pa, pb, pc, pg, pe, pal, pbr, zen, epos, gcap, spos, preq, lock, u;
	reg  [63:0] pval, lo, hi, tm;
	reg  [15:0] cmd_code;
	reg  [1:0]  ph [0:1];
	reg  [31:0] ex [0:1];
	integer     error_cnt, check_count, cycles, k;
	wire        update_tick, sync_event;
	wire [1:0]  zero_capture_valid, ext_capture_valid, preset_done, count_underflow;
	wire [1:0]  count_overflow, interpolation_invalid, track_a_level, track_b_level;
	wire [1:0]  track_c_level, gate_level, ext_capture_level_compat, sync_fault_compat;
	wire [1:0]  data_invalid_compat, update_toggle_compat, data_invalid, host_lock_echo;
	wire [1:0]  second_capture_full, reversal_seen, ext_capture_level;
	wire [1:0]  wire_break, alarm_input_level;
	wire [3:0]  update_cycle_count;
	wire [7:0]  input_entry_count, status_entry_count;
	wire [63:0] count_value, captured_count, second_captured_count;
	wire [31:0] pulse_ratio, pulse_ratio_lowest, pulse_ratio_highest;
	wire [127:0] count_change_time, zero_edge_time, ext_capture_time;

	eip_encoder_inputs #(.NUM_CH(2), .STALL_CYCLES(20)) i_eip_encoder_inputs (
		.core_clk, .sys_rst, .pin_track_a(pa), .pin_track_b(pb), .pin_track_c(pc),
		.pin_gate(pg), .pin_ext_capture(pe), .pin_alarm(pal), .pin_wire_break(pbr),
		.compat_layout, .distributed_clock_operation, .sync_event, .update_tick,
		.zero_capture_en(zen), .ext_capture_pos_en(epos), .ext_capture_neg_en(2'h0),
		.gate_as_capture(gcap), .second_capture_pos_en(spos), .second_capture_neg_en(2'h0),
		.preset_req(preq), .preset_value(pval), .host_lock_req(lock), .lower_limit(lo),
		.upper_limit(hi), .cmd_strobe, .cmd_code, .input_entry_count, .status_entry_count,
		.zero_capture_valid, .ext_capture_valid, .preset_done, .count_underflow,
		.count_overflow, .alarm_input_level, .wire_break, .interpolation_invalid,
		.track_a_level, .track_b_level, .track_c_level, .gate_level,
		.ext_capture_level_compat, .sync_fault_compat, .data_invalid_compat,
		.update_toggle_compat, .count_value, .captured_count, .count_change_time,
		.zero_edge_time, .ext_capture_time, .second_capture_time(), .second_captured_count,
		.pulse_ratio, .pulse_ratio_lowest, .pulse_ratio_highest, .data_invalid,
		.update_cycle_count, .host_lock_echo, .second_capture_full, .reversal_seen,
		.ext_capture_level, .count_outside_limits()
	);
	eip_bus_master_model #(.PERIOD(30)) i_eip_bus_master_model (
		.core_clk, .sys_rst, .run, .skip, .update_tick, .sync_event
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles = cycles + 1;
		if (count_overflow[0] === 1'b1) ovf_seen <= 1'b1;
		if (count_underflow[0] === 1'b1) udf_seen <= 1'b1;
		if (cycles == 5000) begin
			error_cnt = error_cnt + 1;
			give_verdict;
		end
	end

	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input [127:0] seen, input [127:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("FAIL at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge core_clk);
	endtask
	task cmd(input [15:0] c);
		cmd_code = c;
		cmd_strobe = 1'b1;
		cyc(1);
		cmd_strobe = 1'b0;
		cyc(1);
	endtask
	task apulse(input integer h, input integer l);
		pa[0] = 1'b1;
		cyc(h);
		pa[0] = 1'b0;
		cyc(l);
	endtask
	// Gray step on A/B; act low: step must be ignored
	task step(input integer ch, input up, input act);
		ph[ch] = up ? ph[ch] + 2'h1 : ph[ch] - 2'h1;
		pa[ch] = ph[ch][1];
		pb[ch] = ph[ch][1] ^ ph[ch][0];
		if (act)
			ex[ch] = up ? ((ex[ch] >= hi[ch*32+:32]) ? lo[ch*32+:32] : ex[ch] + 32'h1)
				: ((ex[ch] <= lo[ch*32+:32]) ? hi[ch*32+:32] : ex[ch] - 32'h1);
		cyc(6);
		chk(count_value[ch*32+:32], ex[ch]);
	endtask

	initial begin
		{compat_layout, distributed_clock_operation, cmd_strobe, run, skip} = 5'h00;
		{pa, pb, pc, pg, pe, pal, pbr, zen, epos, gcap, spos, preq, lock} = 26'h0;
		{pval, lo, cmd_code, error_cnt, check_count, cycles} = 0;
		hi = {32'h0000FFFF, 32'h00000009};
		{ph[0], ph[1], ex[0], ex[1], ovf_seen, udf_seen} = 0;
		sys_rst = 1'b1;
		cyc(4);
		sys_rst = 1'b0;
		cyc(1);
		chk({input_entry_count, status_entry_count}, 16'h2515);
		chk({count_value, update_cycle_count, preset_done}, 70'h0);
		$display("test reset done");
		for (k = 0; k < 4; k = k + 1) begin
			{pg[0], pc[0], pb[0], pa[0]} = 4'h1 << k;
			cyc(4);
			chk({gate_level[0], track_c_level[0], track_b_level[0], track_a_level[0]},
				4'h1 << k);
		end
		{pg[0], pc[0]} = 2'h0;
		repeat (3) apulse(4, 4);
		apulse(4, 0);
		cmd(16'h9130);
		cmd(16'h9140);
		apulse(4, 4);
		apulse(2, 6);
		apulse(4, 4);
		chk(pulse_ratio[15:0], 16'h3FFF);
		chk(pulse_ratio_lowest[15:0], 16'h3FFF);
		chk(pulse_ratio_highest[15:0], 16'h7FFF);
		cmd(16'h9140);
		chk(pulse_ratio_highest[15:0], 16'h3FFF);
		$display("test duty done");
		pval[31:0] = 32'h00000005;
		preq[0] = 1'b1;
		cyc(2);
		chk({preset_done[0], count_value[31:0]}, 33'h100000005);
		preq[0] = 1'b0;
		cyc(2);
		chk(preset_done[0], 1'b0);
		ex[0] = 32'h00000005;
		repeat (4) step(0, 1, 1);
		{ovf_seen, udf_seen} = 2'h0;
		tm = count_change_time[63:0];
		step(0, 1, 1);
		chk(count_change_time[63:0] != tm, 1'b1);
		chk(ovf_seen, 1'b1);
		step(0, 0, 1);
		chk(udf_seen, 1'b1);
		lock[0] = 1'b1;
		cyc(3);
		chk(host_lock_echo[0], 1'b1);
		step(0, 1, 0);
		lock[0] = 1'b0;
		cyc(3);
		chk(host_lock_echo[0], 1'b0);
		cyc(30);
		chk(interpolation_invalid[0], 1'b1);
		step(0, 1, 1);
		chk(interpolation_invalid[0], 1'b0);
		$display("test count done");
		zen[0] = 1'b1;
		tm = zero_edge_time[63:0];
		pc[0] = 1'b1;
		cyc(5);
		chk({zero_capture_valid[0], captured_count[31:0]}, {1'b1, ex[0]});
		chk(zero_edge_time[63:0] != tm, 1'b1);
		{pc[0], zen[0], compat_layout, epos[0], pe[0]} = 5'h07;
		cyc(5);
		chk({ext_capture_valid[0], captured_count[31:0]}, {1'b1, ex[0]});
		chk({ext_capture_level[0], ext_capture_level_compat[0]}, 2'h3);
		chk(ext_capture_time[63:0] > zero_edge_time[63:0], 1'b1);
		{pe[0], epos[0], gcap[0], spos[0], pg[0]} = 5'h07;
		cyc(5);
		chk({second_capture_full[0], second_captured_count[31:0]}, {1'b1, ex[0]});
		chk({ext_capture_valid[0], zero_capture_valid[0]}, 2'h0);
		tm[31:0] = ex[0];
		pg[0] = 1'b0;
		step(0, 1, 1);
		pg[0] = 1'b1;
		cyc(5);
		chk(second_captured_count[31:0], tm[31:0]);
		{pg[0], spos[0], gcap[0]} = 3'h0;
		step(1, 1, 1);
		chk(count_value[31:0], ex[0]);
		$display("test capture done");
		u = update_cycle_count[1:0];
		t = update_toggle_compat[0];
		step(0, 1, 1);
		run = 1'b1;
		cyc(70);
		chk(update_cycle_count[1:0], u + 2'h1);
		chk(update_toggle_compat[0], !t);
		chk(reversal_seen[0], 1'b0);
		pbr[0] = 1'b1;
		pal[0] = 1'b1;
		cyc(4);
		chk({data_invalid[0], data_invalid_compat[0], wire_break[0], alarm_input_level[0]},
			4'hF);
		{pbr[0], pal[0]} = 2'h0;
		distributed_clock_operation = 1'b1;
		cyc(70);
		chk(sync_fault_compat[0], 1'b0);
		skip = 1'b1;
		cyc(70);
		chk(sync_fault_compat[0], 1'b1);
		skip = 1'b0;
		cyc(70);
		chk(sync_fault_compat[0], 1'b0);
		run = 1'b0;
		cyc(5);
		step(0, 1, 1);
		step(0, 0, 1);
		chk(reversal_seen[0], 1'b1);
		$display("test update done");
		give_verdict;
	end
endmodule // tb_top
